// ===== design/rspc_front_end.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - Calibration watches only the input chosen by the select bit.
// - During calibration integrators hold and no counter increments.
// - Calibration runs at most 28 tests, each three sample intervals long.
// - Calibration fails when the selected input never samples high.
// - Calibration writes its found setting into the five-bit strength field.
// - One strength drives both pull-ups, calibrated or programmed.
// - Calibration tests stretch with the selected sample interval.
// - Inputs are sampled on RTC-derived intervals from 250 us to 2 ms.
// - Rate code 00..11 gives 250 us, 500 us, 1 ms, 2 ms.
// - Mode code 00..11 is off, single, dual, quadrature.
// - Output goes high after the high threshold of net high samples.
// - Output goes low after the low threshold of net low samples.
// - Integrator steps up and down and never restarts on opposite samples.
// - A threshold of four needs four net samples to flip output.
// - Each tick enables pull-up, waits for charge, then disables it and samples on the same edge.
// - Power reset clears counters and registers; a master mode write clears all but the extended enable.
// - 24-bit counters hold until a master mode write clears them.
// - A master mode write resets all other pulse counter registers except the extended enable bit.
// - After a counter reset, counting waits two RTC cycles.
// - Sampling and counting halt while the RTC is not running.
// - Interrupt needs a source enable and the extended enable bit 4.
// - A transition flag sets when a switch opens.
// - Counters only increment and wrap from all ones to zero.
module rspc_front_end
  import rspc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_input_a,
  input wire logic pulse_input_b,
  input wire logic rtc_tick_clock,
  input wire logic rtc_run,
  output logic pullup_en,
  output logic [4:0] pullup_strength,
  output logic pc_irq
);

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= ADDR_STAT);
  endfunction : addr_ok

  function automatic logic [6:0] period_last(input logic [1:0] rate);
    period_last = 7'((RTC_PER_SAMPLE << rate) - 7'd1);
  endfunction : period_last

  function automatic logic [6:0] charge_len(input logic [1:0] duty, input logic [1:0] rate);
    logic [6:0] base;
    base = CHARGE_D0;
    case (duty)
      2'h1: base = CHARGE_D1;
      2'h2: base = CHARGE_D2;
      2'h3: base = CHARGE_D3;
      default: base = CHARGE_D0;
    endcase
    charge_len = 7'(base << rate);
  endfunction : charge_len

  // Zero thresholds act as one so a flip always needs a sample.
  function automatic logic [7:0] thr(input logic [7:0] t);
    thr = (t == 8'h00) ? 8'h01 : t;
  endfunction : thr

  rspc_pins_s sr1, sr2, sr3, lvl;
  rspc_mode_e mode;
  rspc_cal_e cal_state;
  logic [1:0] rate;
  logic [4:0] pu_str;
  logic pu_sel;
  logic [1:0] pu_duty;
  logic cal_fail;
  logic [4:0] cal_test;
  logic [1:0] cal_smp;
  logic cal_done_evt;
  logic cal_fail_evt;
  logic [7:0] dbh, dbl;
  logic [2:0] int0_flag, int0_en, int1_flag, int1_en;
  logic eie_pc;
  logic [6:0] phase;
  logic sample_stb;
  logic [1:0] smp, raw_prev;
  logic [7:0] integ [2];
  logic [1:0] deb, deb_prev;
  logic [23:0] ctr [2];
  logic [1:0] ovf_evt;
  logic [1:0] hold;
  logic rtc_rise, run_ok, mode_wr, pu_wr, wr, cal_busy, count_ok;
  logic [2:0] next_int0, next_int1;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign wr = psel && penable && pwrite && addr_ok(paddr);
  assign mode_wr = wr && (paddr == ADDR_MODE);
  assign pu_wr = wr && (paddr == ADDR_PUCFG);
  assign cal_busy = (cal_state == CAL_TEST);
  assign rtc_rise = (sr2.rtc == sr3.rtc) && sr3.rtc && !lvl.rtc;
  assign run_ok = lvl.run && (mode != MODE_OFF || cal_busy);
  assign smp = {lvl.b, lvl.a};
  assign count_ok = (hold == 2'd0) && !cal_busy;

  // Pins and the RTC come from other domains; a level counts once stages two and three agree.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sr1 <= '0;
      sr2 <= '0;
      sr3 <= '0;
      lvl <= '0;
    end
    else
    begin
      sr1 <= '{run: rtc_run, rtc: rtc_tick_clock, b: pulse_input_b, a: pulse_input_a};
      sr2 <= sr1;
      sr3 <= sr2;
      lvl <= (~(sr2 ^ sr3) & sr3) | ((sr2 ^ sr3) & lvl);
    end
  end

  // Sample sequencer: pull-up on at phase zero, sample and release after the charge time.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase <= 7'd0;
      pullup_en <= 1'b0;
      sample_stb <= 1'b0;
    end
    else
    begin
      sample_stb <= 1'b0;
      if (mode_wr || !run_ok)
      begin
        phase <= 7'd0;
        pullup_en <= 1'b0;
      end
      else if (rtc_rise)
      begin
        if (phase == 7'd0)
          pullup_en <= 1'b1;
        if (phase == charge_len(pu_duty, rate))
        begin
          pullup_en <= 1'b0;
          sample_stb <= 1'b1;
        end
        phase <= (phase == period_last(rate)) ? 7'd0 : 7'(phase + 7'd1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pullup_strength <= STR_RST;
    else
      pullup_strength <= cal_busy ? 5'(cal_test + 5'd1) : pu_str;
  end

  // Master mode register; its write restarts everything else except the extended enable bit.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode <= rspc_mode_e'(MODE_RST);
      rate <= RATE_RST;
      hold <= 2'd0;
    end
    else if (mode_wr)
    begin
      mode <= rspc_mode_e'(pwdata[MODE_LSB +: 2]);
      rate <= pwdata[RATE_LSB +: 2];
      hold <= SYNC_HOLD_RTC;
    end
    else if (rtc_rise && lvl.run && hold != 2'd0)
      hold <= 2'(hold - 2'd1);
  end

  // Pull-up configuration and the calibration engine share the strength field.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pu_str <= STR_RST;
      pu_sel <= 1'b0;
      pu_duty <= DUTY_RST;
      cal_fail <= 1'b0;
      cal_state <= CAL_IDLE;
      cal_test <= 5'd0;
      cal_smp <= 2'd0;
      cal_done_evt <= 1'b0;
      cal_fail_evt <= 1'b0;
    end
    else
    begin
      cal_done_evt <= 1'b0;
      cal_fail_evt <= 1'b0;
      if (mode_wr)
      begin
        pu_str <= STR_RST;
        pu_sel <= 1'b0;
        pu_duty <= DUTY_RST;
        cal_fail <= 1'b0;
        cal_state <= CAL_IDLE;
      end
      else
      begin
        case (cal_state)
          CAL_IDLE:
          begin
            if (pu_wr)
            begin
              pu_str <= pwdata[PU_STR_LSB +: 5];
              pu_sel <= pwdata[PU_SEL_BIT];
              pu_duty <= pwdata[PU_DUTY_LSB +: 2];
              if (pwdata[PU_CAL_BIT])
              begin
                cal_state <= CAL_TEST;
                cal_fail <= 1'b0;
                cal_test <= 5'd0;
                cal_smp <= 2'd0;
              end
            end
          end
          CAL_TEST:
          begin
            if (sample_stb)
            begin
              if (smp[pu_sel])
              begin
                pu_str <= 5'(cal_test + 5'd1);
                cal_done_evt <= 1'b1;
                cal_state <= CAL_IDLE;
              end
              else if (cal_smp == CAL_SAMPLES_LAST)
              begin
                cal_smp <= 2'd0;
                if (cal_test == CAL_TEST_LAST)
                begin
                  cal_fail <= 1'b1;
                  cal_fail_evt <= 1'b1;
                  cal_state <= CAL_IDLE;
                end
                else
                  cal_test <= 5'(cal_test + 5'd1);
              end
              else
                cal_smp <= 2'(cal_smp + 2'd1);
            end
          end
          default: cal_state <= CAL_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dbh <= DB_RST;
      dbl <= DB_RST;
    end
    else if (mode_wr)
    begin
      dbh <= DB_RST;
      dbl <= DB_RST;
    end
    else if (wr && paddr == ADDR_DBH)
      dbh <= pwdata[7:0];
    else if (wr && paddr == ADDR_DBL)
      dbl <= pwdata[7:0];
  end

  // Integrator counts net samples toward the opposite level, so a bounce costs one step.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      integ <= '{default: 8'h00};
      deb <= 2'b00;
      raw_prev <= 2'b00;
    end
    else if (mode_wr)
    begin
      integ <= '{default: 8'h00};
      deb <= 2'b00;
      raw_prev <= 2'b00;
    end
    else if (sample_stb)
    begin
      raw_prev <= smp;
      for (int i = 0; i < 2; i++)
      begin
        if (!cal_busy)
        begin
          if (smp[i] != deb[i])
          begin
            if (integ[i] + 8'h01 >= thr(deb[i] ? dbl : dbh))
            begin
              deb[i] <= smp[i];
              integ[i] <= 8'h00;
            end
            else
              integ[i] <= 8'(integ[i] + 8'h01);
          end
          else if (integ[i] != 8'h00)
            integ[i] <= 8'(integ[i] - 8'h01);
        end
      end
    end
  end

  // Counters survive everything but the block's own power reset and a master mode write.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctr <= '{default: 24'h000000};
      deb_prev <= 2'b00;
      ovf_evt <= 2'b00;
    end
    else
    begin
      deb_prev <= deb;
      ovf_evt <= 2'b00;
      if (mode_wr)
        ctr <= '{default: 24'h000000};
      else if (count_ok)
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (deb[i] && !deb_prev[i] && (i == 0 ? mode != MODE_OFF : mode >= MODE_DUAL))
          begin
            ctr[i] <= 24'(ctr[i] + 24'h000001);
            ovf_evt[i] <= (ctr[i] == 24'hFFFFFF);
          end
        end
      end
    end
  end

  // Flags clear by writing one; a same-cycle event keeps its flag set.
  always_comb
  begin
    next_int0 = int0_flag;
    next_int1 = int1_flag;
    if (wr && paddr == ADDR_INT0)
      next_int0 = int0_flag & ~pwdata[2:0];
    if (wr && paddr == ADDR_INT1)
      next_int1 = int1_flag & ~pwdata[2:0];
    next_int0 = next_int0 | {cal_done_evt, ovf_evt};
    next_int1 = next_int1 | {cal_fail_evt, sample_stb ? (smp & ~raw_prev) : 2'b00};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int0_flag <= INT_RST;
      int1_flag <= INT_RST;
      int0_en <= INT_RST;
      int1_en <= INT_RST;
      eie_pc <= 1'b0;
      pc_irq <= 1'b0;
    end
    else
    begin
      if (mode_wr)
      begin
        int0_flag <= INT_RST;
        int1_flag <= INT_RST;
        int0_en <= INT_RST;
        int1_en <= INT_RST;
      end
      else
      begin
        int0_flag <= next_int0;
        int1_flag <= next_int1;
        if (wr && paddr == ADDR_INT0)
          int0_en <= pwdata[INT_EN_LSB +: 3];
        if (wr && paddr == ADDR_INT1)
          int1_en <= pwdata[INT_EN_LSB +: 3];
      end
      if (wr && paddr == ADDR_EIE)
        eie_pc <= pwdata[EIE_PC_BIT];
      pc_irq <= eie_pc && (|(int0_flag & int0_en) || |(int1_flag & int1_en));
    end
  end

  // Read data is latched in the setup cycle so the access phase needs no wait.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        ADDR_MODE: prdata <= 32'({mode, rate, 4'h0});
        ADDR_PUCFG: prdata <= 32'({pu_duty, cal_fail, cal_busy, pu_sel, 2'h0, pu_str});
        ADDR_DBH: prdata <= 32'(dbh);
        ADDR_DBL: prdata <= 32'(dbl);
        ADDR_INT0: prdata <= 32'({int0_en, 1'b0, int0_flag});
        ADDR_INT1: prdata <= 32'({int1_en, 1'b0, int1_flag});
        ADDR_EIE: prdata <= 32'({eie_pc, 4'h0});
        ADDR_CNT0: prdata <= 32'(ctr[0]);
        ADDR_CNT1: prdata <= 32'(ctr[1]);
        ADDR_STAT: prdata <= 32'({hold != 2'd0, lvl.run, cal_busy, deb});
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  a_cal_freezes_ctr: assert property (cal_busy && !mode_wr |=> ctr[0] == $past(ctr[0]))
    else $error("counter moved during calibration");
  a_mode_clears_ctr: assert property (mode_wr |=> ctr[0] == 24'h0 && ctr[1] == 24'h0)
    else $error("mode write did not clear counters");
  a_mode_resets_cfg: assert property (mode_wr |=> dbh == DB_RST && int0_flag == INT_RST)
    else $error("mode write did not reset configuration");
  a_hold_blocks_count: assert property (hold != 2'd0 && !mode_wr |=> $stable(ctr[1]))
    else $error("counter moved during sync hold");
  a_halt_no_sample: assert property (!lvl.run |=> !sample_stb && !pullup_en)
    else $error("sampling while RTC halted");
  a_irq_needs_eie: assert property ($rose(pc_irq) |-> $past(eie_pc))
    else $error("interrupt without extended enable");
  a_deb_rise_cause: assert property ($rose(deb[0])
    |-> $past(sample_stb) && $past(smp[0]))
    else $error("debounce rose without high sample");
  // A master mode write also drops the output, so it is a legal cause of a fall.
  a_deb_fall_cause: assert property ($fell(deb[1])
    |-> $past(mode_wr) || ($past(sample_stb) && !$past(smp[1])))
    else $error("debounce fell without low sample");
  a_cal_result: assert property (cal_done_evt |-> pu_str == 5'($past(cal_test) + 5'd1))
    else $error("calibration wrote wrong strength");
  a_cal_fail_last: assert property (cal_fail_evt |-> $past(cal_test) == CAL_TEST_LAST)
    else $error("calibration failed early");
  a_ctr_wrap: assert property (!$past(mode_wr) && ctr[0] != $past(ctr[0])
    |-> ctr[0] == 24'($past(ctr[0]) + 24'h1))
    else $error("counter stepped other than by one");
  a_pullup_pulse: assert property ($fell(pullup_en) && !$past(mode_wr) && $past(run_ok)
    |-> sample_stb)
    else $error("pull-up released without sample");

  c_cal_done: cover property (cal_done_evt);
  c_cal_fail: cover property (cal_fail_evt);
  c_ctr_wrap: cover property (ovf_evt[0]);
  c_irq: cover property ($rose(pc_irq));

endmodule : rspc_front_end

// ===== pkg/rspc_pkg.sv
package rspc_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_PUCFG = 8'h04;
  localparam logic [7:0] ADDR_DBH = 8'h08;
  localparam logic [7:0] ADDR_DBL = 8'h0C;
  localparam logic [7:0] ADDR_INT0 = 8'h10;
  localparam logic [7:0] ADDR_INT1 = 8'h14;
  localparam logic [7:0] ADDR_EIE = 8'h18;
  localparam logic [7:0] ADDR_CNT0 = 8'h1C;
  localparam logic [7:0] ADDR_CNT1 = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h24;

  // Field positions.
  localparam int MODE_LSB = 6;
  localparam int RATE_LSB = 4;
  localparam int PU_STR_LSB = 0;
  localparam int PU_SEL_BIT = 7;
  localparam int PU_CAL_BIT = 8;
  localparam int PU_FAIL_BIT = 9;
  localparam int PU_DUTY_LSB = 10;
  localparam int INT_EN_LSB = 4;
  localparam int EIE_PC_BIT = 4;

  // Reset values.
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [4:0] STR_RST = 5'h00;
  localparam logic [1:0] DUTY_RST = 2'h0;
  localparam logic [7:0] DB_RST = 8'h00;
  localparam logic [2:0] INT_RST = 3'h0;

  // Timing: RTC at 32768 Hz, base sample interval 250 us, calibration test 750 us.
  localparam longint RTC_HZ = 32768;
  localparam longint SAMPLE_BASE_NS = 250000;
  localparam longint CAL_TEST_NS = 750000;
  localparam logic [6:0] RTC_PER_SAMPLE = 7'(RTC_HZ * SAMPLE_BASE_NS / 1000000000);
  localparam logic [1:0] CAL_SAMPLES_LAST = 2'(CAL_TEST_NS / SAMPLE_BASE_NS - 1);
  localparam logic [4:0] CAL_TEST_LAST = 5'd27;
  localparam logic [1:0] SYNC_HOLD_RTC = 2'd2;

  // Pull-up on-time within one base interval, in RTC cycles, per duty code.
  localparam logic [6:0] CHARGE_D0 = 7'd2;
  localparam logic [6:0] CHARGE_D1 = 7'd3;
  localparam logic [6:0] CHARGE_D2 = 7'd4;
  localparam logic [6:0] CHARGE_D3 = 7'd6;

  typedef enum logic [1:0] {MODE_OFF, MODE_SINGLE, MODE_DUAL, MODE_QUAD} rspc_mode_e;
  typedef enum logic {CAL_IDLE, CAL_TEST} rspc_cal_e;

  typedef struct packed {
    logic run;
    logic rtc;
    logic b;
    logic a;
  } rspc_pins_s;

endpackage : rspc_pkg

// ===== testbench/rspc_reed_model.sv
`timescale 1ns/1ps
module rspc_reed_model
  import rspc_pkg::*;
#(
  parameter logic [4:0] NEED_A = 5'h02,
  parameter logic [4:0] NEED_B = 5'h05,
  parameter int DECAY = 6
)
(
  input wire logic clk,
  input wire logic pullup_en,
  input wire logic [4:0] pullup_strength,
  input wire logic open_a,
  input wire logic open_b,
  output logic pulse_input_a,
  output logic pulse_input_b
);
  // A closed switch grounds the node.
  // An open one charges only while the shared pull-up is on and strong enough.
  // Leakage pulls it back to ground a few cycles later, so no stale high survives.
  int hold_cnt = 0;
  always_ff @(posedge clk)
  begin
    if (pullup_en)
      hold_cnt <= DECAY;
    else if (hold_cnt > 0)
      hold_cnt <= hold_cnt - 1;
  end
  assign pulse_input_a = open_a && (pullup_en || hold_cnt > 0) && (pullup_strength >= NEED_A);
  assign pulse_input_b = open_b && (pullup_en || hold_cnt > 0) && (pullup_strength >= NEED_B);
endmodule : rspc_reed_model

// ===== testbench/tb_rspc_front_end.sv
`timescale 1ns/1ps
module tb_rspc_front_end
  import rspc_pkg::*;
;
  // The RTC runs far faster than 32768 Hz to keep the run short.
  localparam int RTC_P = 10;
  localparam logic [6:0] CHG [4] = '{CHARGE_D0, CHARGE_D1, CHARGE_D2, CHARGE_D3};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rtc_tick_clock = 1'b0;
  logic rtc_run = 1'b1;
  logic open_a = 1'b0;
  logic open_b = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pulse_input_a;
  logic pulse_input_b;
  logic pullup_en;
  logic [4:0] pullup_strength;
  logic pc_irq;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int tests_run = 0;
  int pu_rises = 0;
  int n;
  int dur;
  realtime t0;
  realtime t1;
  realtime t2;

  rspc_front_end rspc_front_end_inst (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_input_a(pulse_input_a),
    .pulse_input_b(pulse_input_b), .rtc_tick_clock(rtc_tick_clock), .rtc_run(rtc_run),
    .pullup_en(pullup_en), .pullup_strength(pullup_strength), .pc_irq(pc_irq));

  rspc_reed_model rspc_reed_model_inst (.clk(clk), .pullup_en(pullup_en),
    .pullup_strength(pullup_strength), .open_a(open_a), .open_b(open_b),
    .pulse_input_a(pulse_input_a), .pulse_input_b(pulse_input_b));

  initial forever #12.5 clk = ~clk;
  initial
  begin
    #7;
    forever #(RTC_P * 12.5) rtc_tick_clock = ~rtc_tick_clock;
  end
  always @(posedge pullup_en) pu_rises++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd & mask, exp);
  endtask : rdc

  // Each bit sets the switch for one sample window, oldest bit first.
  task automatic feed(input logic [7:0] pat, input int cnt, input logic on_b);
    for (int i = cnt - 1; i >= 0; i--)
    begin
      @(posedge pullup_en);
      if (on_b)
        open_b <= pat[i];
      else
        open_a <= pat[i];
    end
    @(negedge pullup_en);
    repeat (8) @(posedge clk);
  endtask : feed

  task automatic wait_cal;
    // Only the watchdog ends a calibration that never finishes.
    do
      apb(1'b0, ADDR_STAT, 32'h0);
    while (rd[2] !== 1'b0);
  endtask : wait_cal

  task automatic end_test(input string s);
    $display("test %0s done", s);
  endtask : end_test

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (80000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rdc(ADDR_MODE, 32'hFFFFFFFF, 32'h0);
    rdc(ADDR_PUCFG, 32'hFFFFFFFF, 32'h0);
    rdc(ADDR_DBH, 32'hFFFFFFFF, 32'h0);
    rdc(ADDR_CNT0, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    end_test("reset_map");

    // Like firmware, one master mode write comes first and all other setup follows it.
    wr(ADDR_MODE, 32'h80);
    rdc(ADDR_STAT, 32'h10, 32'h10);
    // Thresholds stay above the one-sample bounce that is fed.
    wr(ADDR_DBH, 32'h4);
    wr(ADDR_DBL, 32'h4);
    wr(ADDR_PUCFG, 32'h1F);
    feed(8'h1D, 5, 1'b0);
    rdc(ADDR_STAT, 32'h1, 32'h0);
    feed(8'h01, 1, 1'b0);
    rdc(ADDR_STAT, 32'h1, 32'h1);
    rdc(ADDR_CNT0, 32'hFFFFFFFF, 32'h1);
    rdc(ADDR_INT1, 32'h1, 32'h1);
    feed(8'h00, 3, 1'b0);
    rdc(ADDR_STAT, 32'h1, 32'h1);
    feed(8'h00, 1, 1'b0);
    rdc(ADDR_STAT, 32'h1, 32'h0);
    feed(8'h0F, 4, 1'b1);
    rdc(ADDR_CNT1, 32'hFFFFFFFF, 32'h1);
    check({27'h0, pullup_strength}, 32'h1F);
    wr(ADDR_MODE, 32'h40);
    rdc(ADDR_CNT0, 32'hFFFFFFFF, 32'h0);
    rdc(ADDR_CNT1, 32'hFFFFFFFF, 32'h0);
    rdc(ADDR_DBH, 32'hFFFFFFFF, 32'h0);
    rdc(ADDR_INT1, 32'h7, 32'h0);
    rdc(ADDR_PUCFG, 32'hFFFFFFFF, 32'h0);
    open_b <= 1'b0;
    end_test("debounce");

    for (int r = 0; r < 4; r++)
    begin
      wr(ADDR_MODE, 32'(((r == 0) ? 1 : r) << 6) | 32'(r << 4));
      wr(ADDR_PUCFG, 32'h1F | 32'(r << 10));
      @(posedge pullup_en);
      @(posedge pullup_en);
      t0 = $realtime;
      @(negedge pullup_en);
      t1 = $realtime;
      @(posedge pullup_en);
      t2 = $realtime;
      check(32'(int'((t1 - t0) / 25.0)), 32'(CHG[r] * (1 << r) * RTC_P));
      check(32'(int'((t2 - t0) / 25.0)), 32'((8 << r) * RTC_P));
    end
    wr(ADDR_MODE, 32'h0);
    n = pu_rises;
    repeat (300) @(posedge clk);
    check(32'(pu_rises), 32'(n));
    wr(ADDR_MODE, 32'h40);
    rtc_run <= 1'b0;
    repeat (20) @(posedge clk);
    n = pu_rises;
    repeat (700) @(posedge clk);
    check(32'(pu_rises), 32'(n));
    rtc_run <= 1'b1;
    end_test("rate_duty_halt");

    wr(ADDR_MODE, 32'h80);
    open_a <= 1'b1;
    open_b <= 1'b1;
    wr(ADDR_PUCFG, 32'h180);
    wait_cal();
    rdc(ADDR_CNT0, 32'hFFFFFFFF, 32'h0);
    rdc(ADDR_PUCFG, 32'h21F, 32'h005);
    check({27'h0, pullup_strength}, 32'h5);
    rdc(ADDR_INT0, 32'h7, 32'h4);
    check({31'h0, pc_irq}, 32'h0);
    wr(ADDR_INT0, 32'h40);
    repeat (3) @(posedge clk);
    check({31'h0, pc_irq}, 32'h0);
    wr(ADDR_EIE, 32'h10);
    repeat (3) @(posedge clk);
    check({31'h0, pc_irq}, 32'h1);
    wr(ADDR_INT0, 32'h44);
    repeat (3) @(posedge clk);
    check({31'h0, pc_irq}, 32'h0);
    // Dual mode: the open input b must reach its own counter once calibration has ended.
    repeat (200) @(posedge clk);
    rdc(ADDR_CNT1, 32'hFFFFFFFF, 32'h1);
    open_a <= 1'b0;
    open_b <= 1'b0;
    end_test("cal_pass_irq");

    for (int r = 0; r < 2; r++)
    begin
      wr(ADDR_MODE, 32'h40 | 32'(r << 4));
      wr(ADDR_PUCFG, 32'h100);
      t0 = $realtime;
      wait_cal();
      dur = int'(($realtime - t0) / 25.0);
      n = (dur >= 81 * (8 << r) * RTC_P && dur <= 86 * (8 << r) * RTC_P) ? 1 : 0;
      check(32'(n), 32'h1);
      rdc(ADDR_PUCFG, 32'h200, 32'h200);
      rdc(ADDR_INT1, 32'h4, 32'h4);
    end
    end_test("cal_fail");
    tally_and_finish();
  end
endmodule : tb_rspc_front_end
